// ==== testbench/isp_flash_ctrl_props.sv ====
`timescale 1ns/100ps

// Port-level checks of the flash programmer, bound to its top module.
module isp_props (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // Flash command and code read side.
    input wire logic cpu_stall,
    input wire logic fl_req,
    input wire logic [1:0] fl_op,
    input wire logic [15:0] fl_addr,
    input wire logic [7:0] fl_data,
    input wire logic fl_done,
    input wire logic [7:0] code_rdata,
    input wire logic protect_active
);
    // One clock domain, so clocking and reset are shared.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    property p_stall;
        cpu_stall == fl_req;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall differs from request");
    property p_release;
        fl_req && fl_done |=> !fl_req && !cpu_stall;
    endproperty
    a_release: assert property (p_release)
        else $error("operation not released");
    property p_hold;
        fl_req && !fl_done |=> fl_req && $stable(fl_addr) &&
            $stable(fl_data) && $stable(fl_op);
    endproperty
    a_hold: assert property (p_hold)
        else $error("command changed mid operation");
    property p_launch;
        $rose(fl_req) |-> $past(sfr_wr) && $past(sfr_addr) == 8'hf7 &&
            $past(sfr_wdata[7]);
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch without start write");
    property p_page;
        fl_req && fl_op == 2'h2 |-> fl_addr[8:0] == 9'h000;
    endproperty
    a_page: assert property (p_page)
        else $error("page erase address not aligned");
    property p_chip;
        fl_req && fl_op == 2'h3 |-> fl_addr == 16'hfe00;
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip erase limit wrong");
    property p_svc;
        fl_req && !fl_op[0] |-> fl_addr < 16'hfe00;
    endproperty
    a_svc: assert property (p_svc)
        else $error("service region targeted");
    property p_unprot;
        fl_req && fl_done && fl_op == 2'h3 |=> !protect_active;
    endproperty
    a_unprot: assert property (p_unprot)
        else $error("chip erase left protection on");
    property p_zero;
        protect_active && $past(protect_active) |-> code_rdata == 8'h00;
    endproperty
    a_zero: assert property (p_zero)
        else $error("protected read not zero");
endmodule // isp_props

////////////////////////////////////////////////////////////////
bind isp_flash_ctrl isp_props u_props (.mclk(mclk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .cpu_stall(cpu_stall), .fl_req(fl_req), .fl_op(fl_op),
    .fl_addr(fl_addr), .fl_data(fl_data), .fl_done(fl_done),
    .code_rdata(code_rdata), .protect_active(protect_active));

// ==== testbench/test_in_system_flash_programmer.sv ====
`timescale 1ns/100ps

// Self-checking bench that plays both the core and the flash macro.
module test_in_system_flash_programmer;
    // Stimulus driven by the bench.
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic fl_done = 1'b0;
    logic [7:0] fl_rdata = 8'h5a;
    // Observed outputs.
    logic [7:0] sfr_rdata, fl_data, code_rdata;
    logic [15:0] fl_addr;
    logic [1:0] fl_op;
    logic cpu_stall, fl_req, protect_active, ram_enable, ale_inhibit;
    // Mismatch and comparison counts.
    int n_errors = 0;
    int comparisons = 0;

    isp_flash_ctrl uut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cpu_stall(cpu_stall), .fl_req(fl_req), .fl_op(fl_op),
        .fl_addr(fl_addr), .fl_data(fl_data), .fl_done(fl_done),
        .fl_rdata(fl_rdata), .code_rdata(code_rdata),
        .protect_active(protect_active), .ram_enable(ram_enable),
        .ale_inhibit(ale_inhibit));

    // A 50 ns clock.
    initial begin
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////
    // Compares with case equality so an unknown never matches.
    task automatic check(input string nm, input logic [15:0] seen,
            input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One write; an idle cycle follows so the strobe never doubles up.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge mclk);
        #1 sfr_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // Read data is registered, so it is checked one edge later.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        @(posedge mclk);
        #1 check("rdata", sfr_rdata, exp);
    endtask

    // Address, unlock key, then the start write.
    task automatic launch(input logic [15:0] a, input logic [1:0] op);
        wr(8'hf4, a[15:8]);
        wr(8'hf5, a[7:0]);
        wr(8'hf6, 8'h55);
        wr(8'hf6, 8'haa);
        wr(8'hf6, 8'h55);
        wr(8'hf7, {6'h20, op});
    endtask

    // Runs one operation and answers it as the flash macro would.
    task automatic do_op(input logic [15:0] a, input logic [1:0] op,
            input logic [15:0] ea);
        launch(a, op);
        check("req", fl_req, 1'b1);
        check("stall", cpu_stall, 1'b1);
        check("op", fl_op, op);
        if (op != 2'h1) check("addr", fl_addr, ea);
        check("data", fl_data, 8'h55);
        rd(8'hf7, {6'h20, op});
        repeat (3) @(posedge mclk);
        #1 fl_done = 1'b1;
        @(posedge mclk);
        #1 fl_done = 1'b0;
        check("release", cpu_stall, 1'b0);
        rd(8'hf7, {6'h00, op});
    endtask

    ////////////////////////////////////////////////////////////////
    // Reset values, the unmapped read and the open code path.
    task automatic t_reset();
        rd(8'hbf, 8'h02);
        rd(8'hf4, 8'h00);
        rd(8'hf5, 8'h00);
        rd(8'hf6, 8'h00);
        rd(8'hf7, 8'h00);
        rd(8'h80, 8'h00);
        check("ome", ram_enable, 1'b1);
        check("alei", ale_inhibit, 1'b0);
        check("code", code_rdata, 8'h5a);
        // A new fetch value must reach the code path one edge later.
        fl_rdata = 8'hc3;
        @(posedge mclk);
        #1 check("code", code_rdata, 8'hc3);
    endtask

    // Only the four stored bits of system control read back.
    task automatic t_sysctl();
        wr(8'hbf, 8'hff);
        rd(8'hbf, 8'h87);
        check("alei", ale_inhibit, 1'b1);
        wr(8'hbf, 8'h04);
        rd(8'hbf, 8'h04);
    endtask

    // Start without the key is dropped but the select bits stay.
    task automatic t_locked();
        wr(8'hf7, 8'h81);
        check("req", fl_req, 1'b0);
        rd(8'hf7, 8'h01);
    endtask

    // The documented byte program, then a second start on a spent key.
    task automatic t_program();
        do_op(16'h1005, 2'h0, 16'h1005);
        wr(8'hf7, 8'h80);
        check("spent", fl_req, 1'b0);
    endtask

    // Protect, page erase and chip erase in turn.
    task automatic t_ops();
        do_op(16'h1234, 2'h1, 16'h0000);
        check("prot", protect_active, 1'b1);
        rd(8'hf7, 8'h01);
        check("code", code_rdata, 8'h00);
        do_op(16'h1234, 2'h2, 16'h1200);
        do_op(16'h1234, 2'h3, 16'hfe00);
        check("prot", protect_active, 1'b0);
        rd(8'hf7, 8'h03);
        check("code", code_rdata, 8'hc3);
    endtask

    // Disabled, service region and broken key all launch nothing.
    task automatic t_refuse();
        wr(8'hbf, 8'h00);
        launch(16'h1005, 2'h0);
        check("off", fl_req, 1'b0);
        wr(8'hbf, 8'h04);
        wr(8'hf7, 8'h80);
        check("used", fl_req, 1'b0);
        launch(16'hfe10, 2'h2);
        check("svc", fl_req, 1'b0);
        wr(8'hf6, 8'h55);
        wr(8'hf6, 8'haa);
        wr(8'hf6, 8'h33);
        wr(8'hf6, 8'h55);
        wr(8'hf7, 8'h80);
        check("key", fl_req, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge mclk);
        #1;
        t_reset();
        t_sysctl();
        t_locked();
        t_program();
        t_ops();
        t_refuse();
        tally_and_finish();
    end

    // The tests need under two hundred cycles; 4000 means a hang.
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule // test_in_system_flash_programmer

// ==== verilog/isp_flash_ctrl.sv ====
`timescale 1ns/100ps
`include "isp_regs.svh"

// Contract
// - Start bit one launches selected operation
// - Start writable only after 55,AA,55 key
// - Start set ignored without completed key
// - Latch address, data; stall CPU meanwhile
// - Hardware clears start bit on completion
// - Select: program, protect, page, chip erase
// - Page is 512 bytes, aligned
// - Page erase covers page holding address
// - Chip erase spares service program region
// - Chip erase clears protection
// - Protected flash reads return zero
// - System control bit 2 enables programming
// - Release stall after operation finishes
// - Service region spans FE00 to FFFF
// - Program/page erase there has no effect
// - High and low registers form address
module isp_flash_ctrl (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Special function register port of the core.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Core control.
    output logic cpu_stall,
    // Flash macro command port.
    output logic fl_req,
    output logic [1:0] fl_op,
    output logic [15:0] fl_addr,
    output logic [7:0] fl_data,
    input wire logic fl_done,
    // Code fetch path through the protection gate.
    input wire logic [7:0] fl_rdata,
    output logic [7:0] code_rdata,
    output logic protect_active,
    // Other system control fields.
    output logic ram_enable,
    output logic ale_inhibit
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Software visible registers.
    logic [7:0] addr_high; // Address bits 15 to 8.
    logic [7:0] addr_low; // Address bits 7 to 0.
    logic [7:0] write_byte; // Data for byte program.
    logic [1:0] op_sel; // Function select field.
    logic prog_enable; // Global programming enable.
    logic wdt_flag; // Watchdog reset flag, kept as plain storage.
    logic next_wdt_flag;
    logic [7:0] next_addr_high;
    logic [7:0] next_addr_low;
    logic [7:0] next_write_byte;
    logic [1:0] next_op_sel;
    logic next_prog_enable;
    logic next_ram_enable;
    logic next_ale_inhibit;

    // Sequencer state and command outputs.
    isp_pkg::isp_state_e state;
    isp_pkg::isp_state_e next_state;
    logic next_fl_req;
    logic [1:0] next_fl_op;
    logic [15:0] next_fl_addr;
    logic [7:0] next_fl_data;
    logic next_protect;
    logic next_stall;

    // Read path.
    logic [7:0] next_sfr_rdata;
    logic [7:0] next_code_rdata;

    // Decoded strobes and helpers.
    logic wr_ctrl; // Write to the operation control register.
    logic wr_key; // Write to the write byte register.
    logic start_req; // Software tries to set the start bit.
    logic unlocked; // Key sequence complete.
    logic consume; // Start write takes the unlock.
    logic launch; // Operation goes to the flash.
    logic [15:0] cur_addr; // Address as software composed it.
    logic in_svc; // Address lies in the service region.
    logic no_effect; // Operation would touch the service region.

    ////////////////////////////////////////////////////////////////////////
    // Address composition and decode.

    assign cur_addr = {addr_high, addr_low};
    assign in_svc = (cur_addr >= `ISP_SVC_BASE);
    assign wr_ctrl = sfr_wr && (sfr_addr == `ISP_ADDR_OP_CTRL);
    assign wr_key = sfr_wr && (sfr_addr == `ISP_ADDR_WR_BYTE);
    assign start_req = wr_ctrl && sfr_wdata[`ISP_OPC_START_BIT];

    // A set attempt without the key is dropped here; zero is a no-op.
    assign consume = start_req && unlocked;

    // Program and page erase never reach the service program region.
    assign no_effect = in_svc &&
        ((sfr_wdata[`ISP_OPC_SEL_HI:`ISP_OPC_SEL_LO] ==
          isp_pkg::ISP_OP_BYTE_PROG) ||
         (sfr_wdata[`ISP_OPC_SEL_HI:`ISP_OPC_SEL_LO] ==
          isp_pkg::ISP_OP_PAGE_ERASE));

    // Launch needs the key, the enable, an idle sequencer and a legal
    // target. A disabled launch still spends the unlock.
    assign launch = consume && prog_enable && !no_effect &&
        (state == isp_pkg::ISP_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Key tracker.

    isp_unlock u_unlock (
        .mclk(mclk),
        .rst_n(rst_n),
        .key_wr(wr_key),
        .key_data(sfr_wdata),
        .consume(consume),
        .unlocked(unlocked)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes. The core is stalled while an operation runs, so
    // writes then are not expected; they still land but the flash sees
    // only the copy latched at launch.
    always_comb begin
        next_addr_high = addr_high;
        next_addr_low = addr_low;
        next_write_byte = write_byte;
        next_op_sel = op_sel;
        next_prog_enable = prog_enable;
        next_ram_enable = ram_enable;
        next_ale_inhibit = ale_inhibit;
        next_wdt_flag = wdt_flag;
        if (sfr_wr) begin
            unique case (sfr_addr)
                `ISP_ADDR_FA_HIGH: next_addr_high = sfr_wdata;
                `ISP_ADDR_FA_LOW: next_addr_low = sfr_wdata;
                `ISP_ADDR_WR_BYTE: next_write_byte = sfr_wdata;
                `ISP_ADDR_OP_CTRL: begin
                    next_op_sel =
                        sfr_wdata[`ISP_OPC_SEL_HI:`ISP_OPC_SEL_LO];
                end
                `ISP_ADDR_SYS_CTRL: begin
                    next_prog_enable = sfr_wdata[`ISP_SC_PEN_BIT];
                    next_ram_enable = sfr_wdata[`ISP_SC_OME_BIT];
                    next_ale_inhibit = sfr_wdata[`ISP_SC_ALEI_BIT];
                    next_wdt_flag = sfr_wdata[`ISP_SC_WDR_BIT];
                end
                default: begin
                    // Other addresses belong to other blocks.
                end
            endcase
        end
    end

    // Register storage.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_high <= `ISP_BYTE_RST;
            addr_low <= `ISP_BYTE_RST;
            write_byte <= `ISP_BYTE_RST;
            op_sel <= `ISP_SEL_RST;
            prog_enable <= `ISP_SC_PEN_RST;
            ram_enable <= `ISP_SC_OME_RST;
            ale_inhibit <= `ISP_SC_ALEI_RST;
            wdt_flag <= `ISP_SC_WDR_RST;
        end else begin
            addr_high <= next_addr_high;
            addr_low <= next_addr_low;
            write_byte <= next_write_byte;
            op_sel <= next_op_sel;
            prog_enable <= next_prog_enable;
            ram_enable <= next_ram_enable;
            ale_inhibit <= next_ale_inhibit;
            wdt_flag <= next_wdt_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer. The start bit is the running state itself, so
    // it can never read one without the stall being asserted too.
    always_comb begin
        next_state = state;
        next_fl_req = fl_req;
        next_fl_op = fl_op;
        next_fl_addr = fl_addr;
        next_fl_data = fl_data;
        next_protect = protect_active;
        next_stall = cpu_stall;
        unique case (state)
            isp_pkg::ISP_IDLE: begin
                if (launch) begin
                    next_state = isp_pkg::ISP_RUN;
                    next_fl_req = 1'b1;
                    next_stall = 1'b1;
                    next_fl_op =
                        sfr_wdata[`ISP_OPC_SEL_HI:`ISP_OPC_SEL_LO];
                    next_fl_data = write_byte;
                    next_fl_addr = cur_addr;
                    unique case (isp_pkg::isp_op_e'(next_fl_op))
                        isp_pkg::ISP_OP_PAGE_ERASE: begin
                            // Page base: clear the in-page byte bits.
                            next_fl_addr[`ISP_PAGE_BITS-1:0] = '0;
                        end
                        isp_pkg::ISP_OP_CHIP_ERASE: begin
                            // Erase limit: the macro erases below it.
                            next_fl_addr = `ISP_SVC_BASE;
                        end
                        default: begin
                            // Program and protect keep the address.
                        end
                    endcase
                end
            end
            isp_pkg::ISP_RUN: begin
                if (fl_done) begin
                    next_state = isp_pkg::ISP_IDLE;
                    next_fl_req = 1'b0;
                    next_stall = 1'b0;
                    if (fl_op == isp_pkg::ISP_OP_PROTECT) begin
                        next_protect = 1'b1;
                    end else if (fl_op == isp_pkg::ISP_OP_CHIP_ERASE) begin
                        next_protect = 1'b0;
                    end
                end
            end
        endcase
    end

    // Sequencer storage.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= isp_pkg::ISP_IDLE;
            fl_req <= 1'b0;
            fl_op <= `ISP_SEL_RST;
            fl_addr <= `ISP_SVC_BASE;
            fl_data <= `ISP_BYTE_RST;
            protect_active <= 1'b0;
            cpu_stall <= 1'b0;
        end else begin
            state <= next_state;
            fl_req <= next_fl_req;
            fl_op <= next_fl_op;
            fl_addr <= next_fl_addr;
            fl_data <= next_fl_data;
            protect_active <= next_protect;
            cpu_stall <= next_stall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read paths. Both are registered, which costs one cycle of latency
    // but keeps the outputs free of decode glitches.
    always_comb begin
        next_sfr_rdata = `ISP_ZERO_BYTE;
        unique case (sfr_addr)
            `ISP_ADDR_FA_HIGH: next_sfr_rdata = addr_high;
            `ISP_ADDR_FA_LOW: next_sfr_rdata = addr_low;
            `ISP_ADDR_WR_BYTE: next_sfr_rdata = write_byte;
            `ISP_ADDR_OP_CTRL: begin
                next_sfr_rdata[`ISP_OPC_START_BIT] =
                    (state == isp_pkg::ISP_RUN);
                next_sfr_rdata[`ISP_OPC_SEL_HI:`ISP_OPC_SEL_LO] = op_sel;
            end
            `ISP_ADDR_SYS_CTRL: begin
                next_sfr_rdata[`ISP_SC_WDR_BIT] = wdt_flag;
                next_sfr_rdata[`ISP_SC_PEN_BIT] = prog_enable;
                next_sfr_rdata[`ISP_SC_OME_BIT] = ram_enable;
                next_sfr_rdata[`ISP_SC_ALEI_BIT] = ale_inhibit;
            end
            default: begin
                // Unmapped addresses read zero.
            end
        endcase
        // A protected array hides its contents from every read.
        next_code_rdata = protect_active ? `ISP_PROTECT_READ
                                         : fl_rdata;
    end

    // Read data storage.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= `ISP_ZERO_BYTE;
            code_rdata <= `ISP_ZERO_BYTE;
        end else begin
            sfr_rdata <= next_sfr_rdata;
            code_rdata <= next_code_rdata;
        end
    end

endmodule // isp_flash_ctrl

// ==== verilog/isp_pkg.sv ====
package isp_pkg;

    // Operation codes carried by the two function select bits.
    typedef enum logic [1:0] {
        ISP_OP_BYTE_PROG = 2'h0,
        ISP_OP_PROTECT = 2'h1,
        ISP_OP_PAGE_ERASE = 2'h2,
        ISP_OP_CHIP_ERASE = 2'h3
    } isp_op_e;

    // Sequencer states.
    typedef enum logic {
        ISP_IDLE,
        ISP_RUN
    } isp_state_e;

    // Unlock tracker states.
    typedef enum logic [1:0] {
        ISP_LK_NONE,
        ISP_LK_FIRST,
        ISP_LK_SECOND,
        ISP_LK_OPEN
    } isp_lock_e;

endpackage

// ==== verilog/isp_regs.svh ====
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// Special function register addresses of the programmer.
`define ISP_ADDR_SYS_CTRL 8'hbf
`define ISP_ADDR_FA_HIGH 8'hf4
`define ISP_ADDR_FA_LOW 8'hf5
`define ISP_ADDR_WR_BYTE 8'hf6
`define ISP_ADDR_OP_CTRL 8'hf7

// Field positions of the flash operation control register.
`define ISP_OPC_START_BIT 7
`define ISP_OPC_SEL_HI 1
`define ISP_OPC_SEL_LO 0

// Field positions of the system control register.
`define ISP_SC_WDR_BIT 7
`define ISP_SC_PEN_BIT 2
`define ISP_SC_OME_BIT 1
`define ISP_SC_ALEI_BIT 0

// Reset values of the stored fields.
`define ISP_SC_WDR_RST 1'h0
`define ISP_SC_PEN_RST 1'h0
`define ISP_SC_OME_RST 1'h1
`define ISP_SC_ALEI_RST 1'h0
`define ISP_BYTE_RST 8'h00
`define ISP_SEL_RST 2'h0

// Unlock key written to the flash write byte register.
`define ISP_KEY_FIRST 8'h55
`define ISP_KEY_SECOND 8'haa

// Service program region and page geometry.
`define ISP_SVC_BASE 16'hfe00
`define ISP_PAGE_BITS 9
`define ISP_PROTECT_READ 8'h00
`define ISP_ZERO_BYTE 8'h00

`endif

// ==== verilog/isp_unlock.sv ====
`timescale 1ns/100ps
`include "isp_regs.svh"

// Watches writes to the flash write byte register for the unlock key.
module isp_unlock (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Write byte register traffic.
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    // Start write taken; one unlock allows one start write.
    input wire logic consume,
    // Unlock status.
    output logic unlocked
);

    isp_pkg::isp_lock_e state;
    isp_pkg::isp_lock_e next_state;

    ////////////////////////////////////////////////////////////////////////
    // Next state: any write out of order restarts tracking, but a stray
    // first key byte is itself a valid fresh beginning.
    always_comb begin
        next_state = state;
        if (consume) begin
            next_state = isp_pkg::ISP_LK_NONE;
        end
        if (key_wr) begin
            unique case (state)
                isp_pkg::ISP_LK_FIRST: begin
                    if (key_data == `ISP_KEY_SECOND) begin
                        next_state = isp_pkg::ISP_LK_SECOND;
                    end else if (key_data == `ISP_KEY_FIRST) begin
                        next_state = isp_pkg::ISP_LK_FIRST;
                    end else begin
                        next_state = isp_pkg::ISP_LK_NONE;
                    end
                end
                isp_pkg::ISP_LK_SECOND: begin
                    if (key_data == `ISP_KEY_FIRST) begin
                        next_state = isp_pkg::ISP_LK_OPEN;
                    end else begin
                        next_state = isp_pkg::ISP_LK_NONE;
                    end
                end
                default: begin
                    // Idle and open both restart on a new data write.
                    if (key_data == `ISP_KEY_FIRST) begin
                        next_state = isp_pkg::ISP_LK_FIRST;
                    end else begin
                        next_state = isp_pkg::ISP_LK_NONE;
                    end
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= isp_pkg::ISP_LK_NONE;
        end else begin
            state <= next_state;
        end
    end

    // The start bit is only writable while the key is complete.
    assign unlocked = (state == isp_pkg::ISP_LK_OPEN);

endmodule // isp_unlock
